/* File: serial_register_access_port.sv */
// two-wire slave port giving access to the configuration and status registers
// Overview of operation
// - slave only, 7-bit addressing, works at 100 and 400 kbit/s
// - bytes move most significant bit first, one byte between acknowledge slots
// - read: write loads register address, then read returns that address
// - slave address is 5 fixed bits plus two address select pins
// - burst: first byte at given address, then address steps by one
// - auto-increment stops at 0x7F, further bytes ignored, no wrap
// - multi-byte value held, applied only when least significant byte written
// - stored one-time configuration replaces defaults at power-up
// - writing 0x01 to 0x7F toggles between page 0 and page 1
// - while lock is set, hardware events do not update latched status bits; host writes still do
`timescale 1ns/1ns
`default_nettype none
`include "serial_regs.svh"
module serial_register_access_port #(
  parameter logic [4:0] FIXED_ADDR = 5'h0E,
  parameter logic [7:0] CHIP_ID = 8'h5A // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe_n,
  input wire logic address_select_low_pin,
  input wire logic address_select_high_pin,
  input wire logic [7:0] ref_fault_events,
  input wire logic [7:0] loop_events,
  input wire logic [7:0] monitor_fault_events,
  input wire logic otp_wr_en,
  input wire logic [7:0] otp_wr_addr,
  input wire logic [7:0] otp_wr_data,
  input wire logic [7:0] cfg_rd_addr,
  output var logic [7:0] cfg_rd_data,
  output var logic status_lock,
  output var logic page_active
);
  typedef struct packed {
    serial_pkg::bus_state_e state;
    serial_pkg::phase_e phase;
    logic rw;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [6:0] ptr;
    logic past_end;
    logic page;
    logic [6:0] slave_addr;
    logic scl_prev;
    logic sda_prev;
    logic sda_oe_n;
    logic drive_level;
    logic [7:0] cfg_data;
    logic [3:0][7:0] hold;
    logic [255:0][7:0] mem;
  } state_s;

  function automatic logic [255:0][7:0] reset_image();
    logic [255:0][7:0] m;
    m = '0;
    m[{1'b0, `OFF_CHIP_IDENT}] = CHIP_ID;
    m[{1'b0, `OFF_MON_FAULT_MASK}] = `RST_MON_FAULT_MASK;
    m[{1'b0, `OFF_GUARD_DISQUAL}] = `RST_GUARD_DISQUAL;
    m[{1'b0, `OFF_GUARD_QUAL}] = `RST_GUARD_QUAL;
    return m;
  endfunction

  localparam state_s RESET_STATE = '{
    state: serial_pkg::S_IDLE, phase: serial_pkg::PH_ADDR, rw: 1'b0, bit_cnt: 4'h0,
    sh: 8'h00, tx: 8'hFF, ptr: 7'h00, past_end: 1'b0, page: 1'b0, slave_addr: 7'h00,
    scl_prev: 1'b1, sda_prev: 1'b1, sda_oe_n: 1'b1, drive_level: 1'b0, cfg_data: 8'h00,
    hold: '0, mem: reset_image()};

  // returns {valid, start, end} of the multi-byte group holding an address
  function automatic logic [14:0] mb_group(input logic [6:0] a);
    if (a >= `MB_G0_START && a <= `MB_G0_END)
      return {1'b1, `MB_G0_START, `MB_G0_END};
    else if (a >= `MB_G1_START && a <= `MB_G1_END)
      return {1'b1, `MB_G1_START, `MB_G1_END};
    else if (a >= `MB_G2_START && a <= `MB_G2_END)
      return {1'b1, `MB_G2_START, `MB_G2_END};
    else if (a >= `MB_G3_START && a <= `MB_G3_END)
      return {1'b1, `MB_G3_START, `MB_G3_END};
    else if (a >= `MB_G4_START && a <= `MB_G4_END)
      return {1'b1, `MB_G4_START, `MB_G4_END};
    else if (a >= `MB_G5_START && a <= `MB_G5_END)
      return {1'b1, `MB_G5_START, `MB_G5_END};
    else if (a >= `MB_G6_START && a <= `MB_G6_END)
      return {1'b1, `MB_G6_START, `MB_G6_END};
    else
      return 15'h0000;
  endfunction

  state_s st_q;
  state_s st_d;
  logic [3:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic sel_lo_f;
  logic sel_hi_f;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic [14:0] grp;
  logic [6:0] gs;
  logic [6:0] ge;

  // every pin from the host side goes through the agreement synchroniser
  pin_sync #(
    .WIDTH(4),
    .RESET_VAL(4'hF)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din({address_select_high_pin, address_select_low_pin, sda_in, scl}),
    .dout(pins_f)
  );
  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign sel_lo_f = pins_f[2];
  assign sel_hi_f = pins_f[3];

  // link events found from the sampled scl and sda levels
  assign rise = scl_f & ~st_q.scl_prev;
  assign fall = ~scl_f & st_q.scl_prev;
  assign start_c = scl_f & st_q.scl_prev & st_q.sda_prev & ~sda_f;
  assign stop_c = scl_f & st_q.scl_prev & ~st_q.sda_prev & sda_f;

  // byte returned for the current pointer; page register reads on both pages
  always_comb
  begin
    if (st_q.past_end)
      rd_byte = `PAST_END_READ;
    else if (st_q.ptr == `OFF_PAGE_SELECT)
      rd_byte = {7'h00, st_q.page};
    else
      rd_byte = st_q.mem[{st_q.page, st_q.ptr}];
  end

  assign grp = mb_group(st_q.ptr);
  assign gs = grp[13:7];
  assign ge = grp[6:0];

  // next state: link engine, register writes, then hardware status events
  always_comb
  begin
    st_d = st_q;
    wr_fire = 1'b0;
    st_d.scl_prev = scl_f;
    st_d.sda_prev = sda_f;
    if (otp_wr_en)
    begin
      st_d.mem[otp_wr_addr] = otp_wr_data;
    end
    if (start_c)
    begin
      // repeated start also lands here and restarts addressing
      st_d.state = serial_pkg::S_RX;
      st_d.phase = serial_pkg::PH_ADDR;
      st_d.bit_cnt = 4'h0;
      st_d.sda_oe_n = 1'b1;
      st_d.slave_addr = {FIXED_ADDR, sel_hi_f, sel_lo_f};
    end
    else if (stop_c)
    begin
      st_d.state = serial_pkg::S_IDLE;
      st_d.sda_oe_n = 1'b1;
    end
    else
    begin
      case (st_q.state)
        serial_pkg::S_RX:
        begin
          if (rise && st_q.bit_cnt < `BITS_PER_BYTE)
          begin
            st_d.sh = {st_q.sh[6:0], sda_f};
            st_d.bit_cnt = 4'(st_q.bit_cnt + 4'h1);
          end
          if (fall && st_q.bit_cnt == `BITS_PER_BYTE)
          begin
            st_d.bit_cnt = 4'h0;
            st_d.state = serial_pkg::S_ACK;
            st_d.sda_oe_n = 1'b0;
            case (st_q.phase)
              serial_pkg::PH_ADDR:
              begin
                st_d.rw = st_q.sh[0];
                if (st_q.sh[7:1] != st_q.slave_addr)
                begin
                  st_d.state = serial_pkg::S_IDLE;
                  st_d.sda_oe_n = 1'b1;
                end
              end
              serial_pkg::PH_REG:
              begin
                st_d.ptr = st_q.sh[6:0];
                st_d.past_end = 1'b0;
              end
              default:
              begin
                wr_fire = ~st_q.past_end;
              end
            endcase
          end
        end
        serial_pkg::S_ACK:
        begin
          if (fall)
          begin
            st_d.sda_oe_n = 1'b1;
            st_d.state = serial_pkg::S_RX;
            if (st_q.phase == serial_pkg::PH_ADDR && st_q.rw)
            begin
              st_d.phase = serial_pkg::PH_RDATA;
              st_d.state = serial_pkg::S_TX;
              st_d.tx = rd_byte;
              st_d.sda_oe_n = rd_byte[7];
            end
            else if (st_q.phase == serial_pkg::PH_ADDR)
              st_d.phase = serial_pkg::PH_REG;
            else
              st_d.phase = serial_pkg::PH_WDATA;
          end
        end
        serial_pkg::S_TX:
        begin
          if (fall)
          begin
            if (st_q.bit_cnt == 4'h7)
            begin
              st_d.bit_cnt = 4'h0;
              st_d.sda_oe_n = 1'b1;
              st_d.state = serial_pkg::S_MACK;
            end
            else
            begin
              st_d.bit_cnt = 4'(st_q.bit_cnt + 4'h1);
              st_d.tx = {st_q.tx[6:0], 1'b1};
              st_d.sda_oe_n = st_q.tx[6];
            end
          end
        end
        serial_pkg::S_MACK:
        begin
          if (rise)
          begin
            // byte went out: step pointer, stop at the last address
            if (st_q.ptr == `LAST_AUTO_ADDR)
              st_d.past_end = 1'b1;
            else
              st_d.ptr = 7'(st_q.ptr + 7'h01);
            st_d.state = sda_f ? serial_pkg::S_IDLE : serial_pkg::S_RNEXT;
          end
        end
        serial_pkg::S_RNEXT:
        begin
          if (fall)
          begin
            st_d.state = serial_pkg::S_TX;
            st_d.tx = rd_byte;
            st_d.sda_oe_n = rd_byte[7];
          end
        end
        default:
        begin
          st_d.sda_oe_n = 1'b1;
        end
      endcase
    end
    // register write side effects for one accepted data byte
    if (wr_fire)
    begin
      if (st_q.ptr == `OFF_PAGE_SELECT)
      begin
        if (st_q.sh == `PAGE_TOGGLE_VALUE)
          st_d.page = ~st_q.page;
      end
      else if (!st_q.page && grp[14])
      begin
        // partial values are parked so the core never sees a torn value
        st_d.hold[2'(st_q.ptr - gs)] = st_q.sh;
        if (st_q.ptr == ge)
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (7'(gs + 7'(i)) < ge)
              st_d.mem[{1'b0, 7'(gs + 7'(i))}] = st_q.hold[i];
          end
          st_d.mem[{1'b0, ge}] = st_q.sh;
        end
      end
      else
      begin
        // identification byte is plain storage, reset restores it
        st_d.mem[{st_q.page, st_q.ptr}] = st_q.sh;
      end
      if (st_q.ptr == `LAST_AUTO_ADDR)
        st_d.past_end = 1'b1;
      else
        st_d.ptr = 7'(st_q.ptr + 7'h01);
    end
    // events applied after the write so a set beats a same-cycle clear
    if (!st_q.mem[{1'b0, `OFF_STATUS_LOCK}][`LOCK_BIT])
    begin
      st_d.mem[{1'b0, `OFF_REF_FAULT_STATUS}] = st_d.mem[{1'b0, `OFF_REF_FAULT_STATUS}] | ref_fault_events;
      st_d.mem[{1'b0, `OFF_LOOP_STATUS}] = st_d.mem[{1'b0, `OFF_LOOP_STATUS}] | loop_events;
      st_d.mem[{1'b0, `OFF_MON_FAULTS}] = st_d.mem[{1'b0, `OFF_MON_FAULTS}] | monitor_fault_events;
    end
    st_d.cfg_data = st_q.mem[cfg_rd_addr];
  end

  // the single state register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_q <= RESET_STATE;
    else
      st_q <= st_d;
  end

  assign sda_out = st_q.drive_level;
  assign sda_oe_n = st_q.sda_oe_n;
  assign cfg_rd_data = st_q.cfg_data;
  assign status_lock = st_q.mem[{1'b0, `OFF_STATUS_LOCK}][`LOCK_BIT];
  assign page_active = st_q.page;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_own_addr_only;
    st_q.state == serial_pkg::S_ACK && st_q.phase == serial_pkg::PH_ADDR |-> $past(st_q.sh[7:1]) == st_q.slave_addr;
  endproperty
  a_own_addr_only: assert property (p_own_addr_only) else $error("acknowledged a foreign address");

  property p_slave_addr;
    start_c |=> st_q.slave_addr == {FIXED_ADDR, $past(sel_hi_f), $past(sel_lo_f)};
  endproperty
  a_slave_addr: assert property (p_slave_addr) else $error("slave address not from pins");

  property p_lock_freeze;
    status_lock && !wr_fire && !otp_wr_en
      |=> st_q.mem[2] == $past(st_q.mem[2]) && st_q.mem[3] == $past(st_q.mem[3])
        && st_q.mem[7] == $past(st_q.mem[7]);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("status changed while locked");

  property p_page_toggle;
    wr_fire && st_q.ptr == 7'h7F && st_q.sh == 8'h01 |=> page_active != $past(page_active);
  endproperty
  a_page_toggle: assert property (p_page_toggle) else $error("page did not toggle");

  property p_no_wrap;
    st_q.past_end |-> st_q.ptr == 7'h7F;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("pointer wrapped past the last address");

  property p_step;
    wr_fire && st_q.ptr != 7'h7F |=> st_q.ptr == 7'($past(st_q.ptr) + 7'h01) && !st_q.past_end;
  endproperty
  a_step: assert property (p_step) else $error("burst pointer did not step by one");

  property p_mb_hold;
    wr_fire && !st_q.page && grp[14] && st_q.ptr != ge && !otp_wr_en
      |=> st_q.mem[{1'b0, $past(st_q.ptr)}] == $past(st_q.mem[{1'b0, st_q.ptr}]);
  endproperty
  a_mb_hold: assert property (p_mb_hold) else $error("partial multi-byte value applied early");

  property p_tx_msb;
    st_q.state == serial_pkg::S_ACK && st_q.rw && st_q.phase == serial_pkg::PH_ADDR && fall && !start_c && !stop_c
      |=> st_q.sda_oe_n == st_q.tx[7] ##1 st_q.tx == $past(st_q.tx);
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("read byte not sent msb first");

  property p_id_write;
    wr_fire && st_q.ptr == 7'h00 && !otp_wr_en |=> st_q.mem[{$past(st_q.page), 7'h00}] == $past(st_q.sh);
  endproperty
  a_id_write: assert property (p_id_write) else $error("identification write not stored");
endmodule
`default_nettype wire

/* File: serial_regs.svh */
// register offsets, field positions, reset values and bits per byte of the serial access port
`ifndef SERIAL_REGS_SVH
`define SERIAL_REGS_SVH

// register offsets (7-bit serial address space, one page)
`define OFF_CHIP_IDENT 7'h00
`define OFF_REF_FAULT_STATUS 7'h02
`define OFF_LOOP_STATUS 7'h03
`define OFF_REF_FAULT_MASK 7'h04
`define OFF_LOOP_MASK 7'h05
`define OFF_MON_FAULTS 7'h07
`define OFF_MON_FAULT_MASK 7'h09
`define OFF_REF_INPUT_TYPE 7'h0A
`define OFF_GUARD_DISQUAL 7'h0B
`define OFF_GUARD_QUAL 7'h0C
`define OFF_STATUS_LOCK 7'h0D
`define OFF_PAGE_SELECT 7'h7F

// reset values
`define RST_MON_FAULT_MASK 8'h66
`define RST_GUARD_DISQUAL 8'hAA
`define RST_GUARD_QUAL 8'h55

// field positions and command values
`define LOCK_BIT 0
`define PAGE_TOGGLE_VALUE 8'h01
`define LAST_AUTO_ADDR 7'h7F
`define PAST_END_READ 8'hFF

// multi-byte value groups on page 0 (most significant byte first)
`define MB_G0_START 7'h10
`define MB_G0_END 7'h11
`define MB_G1_START 7'h12
`define MB_G1_END 7'h13
`define MB_G2_START 7'h14
`define MB_G2_END 7'h17
`define MB_G3_START 7'h50
`define MB_G3_END 7'h51
`define MB_G4_START 7'h52
`define MB_G4_END 7'h53
`define MB_G5_START 7'h54
`define MB_G5_END 7'h57
`define MB_G6_START 7'h73
`define MB_G6_END 7'h76

// bits per byte on the link
`define BITS_PER_BYTE 4'd8

`endif

/* File: serial_pkg.sv */
// types shared by the serial access port
package serial_pkg;
  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_MACK,
    S_RNEXT
  } bus_state_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_REG,
    PH_WDATA,
    PH_RDATA
  } phase_e;
endpackage

/* File: pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] dout
);
  // first stage is read by the second stage only
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // output follows only once stages two and three agree
      always_ff @(posedge ref_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_q[i] <= RESET_VAL[i];
          s2_q[i] <= RESET_VAL[i];
          s3_q[i] <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end
        else
        begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i])
          begin
            dout[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: i2c_host_model.sv */
// behavioural two-wire bus master that stands on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  output var logic scl,
  output var logic host_low,
  input wire logic sda
);
  localparam int Q = 200; // quarter of the 800 ns link period
  // bits use a long low phase: the port lets go of the line about 450 ns after a fall
  localparam int LOW_T = 500;
  localparam int HIGH_T = 300;
  // bus idles released, link clock stands high between frames
  initial
  begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  // start or repeated start: data falls while the link clock is high
  task automatic start();
    #Q host_low = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) host_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  // stop: data rises while the link clock is high, then all released
  task automatic stop();
    #Q host_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) host_low = 1'b0;
    #(4*Q);
  endtask
  // one bit; sampled late in the high phase since the port answers slowly
  task automatic clk_bit(input logic b, output logic s);
    #Q host_low = ~b;
    #(LOW_T-Q) scl = 1'b1;
    #(HIGH_T-10) s = sda;
    #10 scl = 1'b0;
  endtask
  // one byte out, most significant bit first, then the acknowledge slot
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  // one byte in, then acknowledge or, on the last byte, not
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the two-wire register access port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [4:0] FIX = 5'h0E;
  localparam logic [7:0] ID = 8'h5A; // arbitrary value
  localparam int LIMIT = 80000;
  localparam int SETTLE = 50000; // 5 ms of system clock
  logic ref_clk, rstn, pin_lo, pin_hi, otp_wr_en, status_lock, page_active, sda_out, sda_oe_n;
  logic [7:0] ref_ev, loop_ev, mon_ev, otp_wr_addr, otp_wr_data, cfg_rd_addr, cfg_rd_data;
  logic [7:0] rbuf [16];
  logic [6:0] sa;
  wire scl, host_low, sda;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // open-drain line with pull-up, low when either side pulls
  assign sda = ~(host_low | (~sda_oe_n & ~sda_out));
  assign sa = {FIX, pin_hi, pin_lo};
  serial_register_access_port #(.FIXED_ADDR(FIX), .CHIP_ID(ID)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_low_pin(pin_lo),
    .address_select_high_pin(pin_hi), .ref_fault_events(ref_ev), .loop_events(loop_ev),
    .monitor_fault_events(mon_ev), .otp_wr_en(otp_wr_en), .otp_wr_addr(otp_wr_addr),
    .otp_wr_data(otp_wr_data), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
    .status_lock(status_lock), .page_active(page_active));
  i2c_host_model u_host (.scl(scl), .host_low(host_low), .sda(sda));
  // 10 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // cut a hang short
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic do_reset();
    @(negedge ref_clk) rstn = 1'b0;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
  // address byte alone, reporting the acknowledge
  task automatic probe(input logic [6:0] a7, output logic ack);
    u_host.start();
    u_host.send({a7, 1'b0}, ack);
    u_host.stop();
  endtask
  // write: address, register byte, up to three data bytes; n = 0 only loads the pointer
  task automatic wr(input logic [6:0] ra, input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00);
    logic [7:0] d [3];
    logic a;
    d = '{b0, b1, b2};
    u_host.start();
    u_host.send({sa, 1'b0}, a);
    chk("address ack", 8'h01, {7'h00, a});
    u_host.send({1'b0, ra}, a);
    chk("register ack", 8'h01, {7'h00, a});
    for (int i = 0; i < n; i++)
    begin
      u_host.send(d[i], a);
      chk("data ack", 8'h01, {7'h00, a});
    end
    u_host.stop();
  endtask
  // two-stage read into rbuf, last byte not acknowledged
  task automatic rd(input logic [6:0] ra, input int n);
    logic a;
    wr(ra, 0, 8'h00);
    u_host.start();
    u_host.send({sa, 1'b1}, a);
    chk("read address ack", 8'h01, {7'h00, a});
    for (int i = 0; i < n; i++)
      u_host.recv(i == n - 1, rbuf[i]);
    u_host.stop();
  endtask
  task automatic rdchk(input logic [6:0] ra, input int n, input logic [7:0] e0, e1 = 8'h00, e2 = 8'h00);
    logic [7:0] e [3];
    e = '{e0, e1, e2};
    rd(ra, n);
    for (int i = 0; i < n; i++)
      chk("read data", e[i], rbuf[i]);
  endtask
  task automatic core_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk) cfg_rd_addr = a;
    repeat (2) @(negedge ref_clk);
    chk("core read", e, cfg_rd_data);
  endtask
  task automatic events(input logic [7:0] r, input logic [7:0] l, input logic [7:0] m);
    @(negedge ref_clk);
    ref_ev = r;
    loop_ev = l;
    mon_ev = m;
    @(negedge ref_clk);
    ref_ev = 8'h00;
    loop_ev = 8'h00;
    mon_ev = 8'h00;
  endtask
  // reset values, read as one burst from the bottom of the map
  task automatic s_defaults();
    logic [7:0] t [14];
    t = '{ID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h66, 8'h00, 8'hAA, 8'h55, 8'h00};
    rd(7'h00, 14);
    for (int i = 0; i < 14; i++)
      chk("reset value", t[i], rbuf[i]);
    chk("page after reset", 8'h00, {7'h00, page_active});
  endtask
  // burst write, then one past the end: no wrap to the bottom
  task automatic s_burst();
    wr(7'h04, 2, 8'h3C, 8'hC3);
    rdchk(7'h04, 2, 8'h3C, 8'hC3);
    wr(7'h7E, 3, 8'h11, 8'h00, 8'h22);
    rdchk(7'h7E, 3, 8'h11, 8'h00, 8'hFF);
    rdchk(7'h00, 1, ID);
  endtask
  // multi-byte value, most significant byte first, applied on the last byte
  task automatic s_multi();
    wr(7'h10, 1, 8'hAB);
    rdchk(7'h10, 2, 8'h00, 8'h00);
    wr(7'h11, 1, 8'hCD);
    rdchk(7'h10, 2, 8'hAB, 8'hCD);
    core_rd(8'h10, 8'hAB);
  endtask
  // page toggle; page 1 space must not alias page 0
  task automatic s_page();
    wr(7'h7F, 1, 8'h01);
    chk("page", 8'h01, {7'h00, page_active});
    rdchk(7'h7F, 1, 8'h01);
    wr(7'h04, 1, 8'h77);
    wr(7'h7F, 1, 8'h01);
    chk("page", 8'h00, {7'h00, page_active});
    rdchk(7'h04, 1, 8'h3C);
    core_rd(8'h84, 8'h77);
  endtask
  // latched status: frozen while locked, set when unlocked, cleared by the locked procedure
  task automatic s_status();
    wr(7'h0D, 1, 8'h01);
    chk("lock", 8'h01, {7'h00, status_lock});
    events(8'h81, 8'h42, 8'h18);
    rdchk(7'h02, 2, 8'h00, 8'h00);
    wr(7'h0D, 1, 8'h00);
    chk("unlock", 8'h00, {7'h00, status_lock});
    events(8'h81, 8'h42, 8'h18);
    rdchk(7'h02, 2, 8'h81, 8'h42);
    rdchk(7'h07, 1, 8'h18);
    wr(7'h0D, 1, 8'h01);
    wr(7'h02, 2, 8'h00, 8'h00);
    wr(7'h0D, 1, 8'h00);
    // the host lets a cleared latched register settle before reading it
    repeat (SETTLE) @(negedge ref_clk);
    rdchk(7'h02, 2, 8'h00, 8'h00);
  endtask
  // every pin setting against every pin address, plus a wrong fixed part
  task automatic s_foreign();
    logic a;
    for (int p = 0; p < 4; p++)
    begin
      @(negedge ref_clk);
      pin_hi = p[1];
      pin_lo = p[0];
      for (int k = 0; k < 5; k++)
      begin
        probe((k < 4) ? {FIX, k[1:0]} : {FIX ^ 5'h10, p[1:0]}, a);
        chk("slave ack", {7'h00, k == p}, {7'h00, a});
      end
    end
    pin_hi = 1'b0;
    pin_lo = 1'b1;
  endtask
  // identity overwrite lasts until reset; stored configuration loaded by the core
  task automatic s_ident();
    wr(7'h00, 1, 8'hE7);
    rdchk(7'h00, 1, 8'hE7);
    @(negedge ref_clk);
    otp_wr_addr = 8'h0A;
    otp_wr_data = 8'h5C;
    otp_wr_en = 1'b1;
    @(negedge ref_clk) otp_wr_en = 1'b0;
    rdchk(7'h0A, 1, 8'h5C);
    do_reset();
    rdchk(7'h00, 1, ID);
  endtask
  // main sequence
  initial
  begin
    rstn = 1'b0;
    pin_lo = 1'b1;
    pin_hi = 1'b0;
    ref_ev = 8'h00;
    loop_ev = 8'h00;
    mon_ev = 8'h00;
    otp_wr_en = 1'b0;
    otp_wr_addr = 8'h00;
    otp_wr_data = 8'h00;
    cfg_rd_addr = 8'h00;
    do_reset();
    s_defaults();
    s_burst();
    s_multi();
    s_page();
    s_status();
    s_foreign();
    s_ident();
    end_of_test();
  end
endmodule
`default_nettype wire
